// File: hdl/ccl_regs.vh
// Register offsets, field positions, reset values and timing for the comparator control logic
// Operation
// - Raw result high when selected positive input exceeds selected negative input.
// - Mux enabled and converter off: channel codes 000-011 pick converter pins 0-3.
// - Mux disabled or converter enabled: dedicated negative pin feeds negative input.
// - Writing one to disable bit 7 powers comparator off, at any time.
// - Bandgap select bit 6 set substitutes bandgap for the positive input.
// - Raw result is synchronised before status bit, one to two cycles late.
// - Event flag sets when synchronised output shows the event chosen by mode.
// - Flag clears on vector taken or software writing one; zero leaves it.
// - Interrupt requested only with flag, enable bit 3 and global enable set.
// - Mode bits 1:0: 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Reserved control bit 2 and input disable bits 7:6 read zero.
// - Pin input-disable bits 5:4 turn off buffer; port status reads zero.
`ifndef CCL_REGS_VH
`define CCL_REGS_VH

// Register word indices; the bus byte address is four times the index
`define CCL_ADDR_CONV_B       4'h3
`define CCL_ADDR_COMP_CS      4'h8
`define CCL_ADDR_DIDR         4'h9
`define CCL_ADDR_CONV_A       4'hA
`define CCL_ADDR_CONV_CHAN    4'hB
`define CCL_ADDR_STATUS_WORD  4'hC

`define CCL_CONV_B_MUXEN      6
`define CCL_CONV_B_WMASK      8'h57
`define CCL_CONV_A_EN         7
`define CCL_CS_DISABLE        7
`define CCL_CS_BANDGAP        6
`define CCL_CS_OUT            5
`define CCL_CS_FLAG           4
`define CCL_CS_IRQEN          3
`define CCL_CS_WMASK          8'hCB
`define CCL_DIDR_WMASK        8'h30
`define CCL_DIDR_NEG          5
`define CCL_DIDR_POS          4
`define CCL_SW_GLOBAL_IE      7

`define CCL_MODE_TOGGLE       2'h0
`define CCL_MODE_FALL         2'h2
`define CCL_MODE_RISE         2'h3

`define CCL_RESET_BYTE        8'h00
`define CCL_SYNC_STAGES       2

`endif

// File: hdl/ccl_comparator_control.v
// Comparator control logic: input steering, power, output sync, events and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ccl_regs.vh"

module ccl_comparator_control #(
    parameter                   ADDR_W = 6
) (
    input  wire                 aclk,
    input  wire                 aresetn,
    input  wire [ADDR_W-1:0]    s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [ADDR_W-1:0]    s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    input  wire                 positive_input_pin,
    input  wire                 negative_input_pin,
    input  wire [3:0]           converter_pin,
    input  wire                 bandgap_level,
    input  wire                 positive_pin_digital,
    input  wire                 negative_pin_digital,
    input  wire                 vector_taken,
    output reg                  comparator_power_off,
    output reg                  positive_pin_input_off,
    output reg                  negative_pin_input_off,
    output reg                  positive_pin_status,
    output reg                  negative_pin_status,
    output reg                  comparator_irq
);

    // Word index decode of the AXI byte address, unaligned addresses miss
    function is_addr;
        input [ADDR_W-1:0] a;
        input [ADDR_W-3:0] idx;
        begin
            is_addr = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
        end
    endfunction

    // Masked byte update from a write word
    function [7:0] merge_byte;
        input [7:0] old;
        input [7:0] new_val;
        input [7:0] mask;
        begin
            merge_byte = (old & ~mask) | (new_val & mask);
        end
    endfunction

    reg  [7:0]          conv_b_reg;
    reg  [7:0]          conv_a_reg;
    reg  [7:0]          conv_chan_reg;
    reg  [7:0]          status_word_reg;
    reg  [7:0]          didr_reg;
    reg                 comp_disable_reg;
    reg                 bandgap_sel_reg;
    reg                 irq_en_reg;
    reg  [1:0]          event_mode_reg;
    reg                 event_flag_reg;
    reg                 event_flag_next;
    reg                 sync1_reg;
    reg                 sync2_reg;
    reg                 sync_prev_reg;
    reg                 aw_held_reg;
    reg                 w_held_reg;
    reg  [ADDR_W-1:0]   aw_addr_reg;
    reg  [31:0]         w_data_reg;
    reg  [3:0]          w_strb_reg;

    wire                positive_sel;
    wire                negative_sel;
    wire                raw_result;
    wire                rise_evt;
    wire                fall_evt;
    reg                 event_hit;
    wire                do_write;
    wire [7:0]          wbyte;
    wire                wlane;
    wire [7:0]          cs_view;

    // Positive input: bandgap or dedicated pin
    assign positive_sel = bandgap_sel_reg ? bandgap_level : positive_input_pin;

    // Negative input: shared converter pins only with mux on and converter off
    assign negative_sel = (conv_b_reg[`CCL_CONV_B_MUXEN] && !conv_a_reg[`CCL_CONV_A_EN]
                           && !conv_chan_reg[2]) ? converter_pin[conv_chan_reg[1:0]]
                                                 : negative_input_pin;

    // Digital model of the analog compare
    assign raw_result = positive_sel & ~negative_sel;

    // Two-stage synchroniser, frozen while powered down
    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg     <= 1'b0;
            sync2_reg     <= 1'b0;
            sync_prev_reg <= 1'b0;
        end else if (!comp_disable_reg) begin
            sync1_reg     <= raw_result;
            sync2_reg     <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    // Edge detection against previous synchronised value
    assign rise_evt = sync2_reg & ~sync_prev_reg;
    assign fall_evt = ~sync2_reg & sync_prev_reg;

    // Event selection by mode
    always @* begin
        case (event_mode_reg)
            `CCL_MODE_TOGGLE: event_hit = rise_evt | fall_evt;
            `CCL_MODE_FALL:   event_hit = fall_evt;
            `CCL_MODE_RISE:   event_hit = rise_evt;
            default:          event_hit = 1'b0;
        endcase
    end

    // Write channel capture, address and data in either order
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wbyte    = w_data_reg[7:0];
    assign wlane    = w_strb_reg[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= {ADDR_W{1'b0}};
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_held_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_held_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (is_addr(aw_addr_reg, `CCL_ADDR_CONV_B) || is_addr(aw_addr_reg, `CCL_ADDR_COMP_CS)
                                 || is_addr(aw_addr_reg, `CCL_ADDR_DIDR) || is_addr(aw_addr_reg, `CCL_ADDR_CONV_A)
                                 || is_addr(aw_addr_reg, `CCL_ADDR_CONV_CHAN)
                                 || is_addr(aw_addr_reg, `CCL_ADDR_STATUS_WORD)) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
            end
        end
    end

    // Event flag: hardware set wins over any clear
    always @* begin
        event_flag_next = event_flag_reg;
        if (vector_taken) begin
            event_flag_next = 1'b0;
        end
        if (do_write && wlane && is_addr(aw_addr_reg, `CCL_ADDR_COMP_CS) && wbyte[`CCL_CS_FLAG]) begin
            event_flag_next = 1'b0;
        end
        if (event_hit && !comp_disable_reg) begin
            event_flag_next = 1'b1;
        end
    end

    // Control register storage
    always @(posedge aclk) begin
        if (!aresetn) begin
            conv_b_reg       <= `CCL_RESET_BYTE;
            conv_a_reg       <= `CCL_RESET_BYTE;
            conv_chan_reg    <= `CCL_RESET_BYTE;
            status_word_reg  <= `CCL_RESET_BYTE;
            didr_reg         <= `CCL_RESET_BYTE;
            comp_disable_reg <= 1'b0;
            bandgap_sel_reg  <= 1'b0;
            irq_en_reg       <= 1'b0;
            event_mode_reg   <= 2'h0;
            event_flag_reg   <= 1'b0;
        end else begin
            event_flag_reg <= event_flag_next;
            if (do_write && wlane) begin
                if (is_addr(aw_addr_reg, `CCL_ADDR_CONV_B)) begin
                    conv_b_reg <= merge_byte(conv_b_reg, wbyte, `CCL_CONV_B_WMASK);
                end
                if (is_addr(aw_addr_reg, `CCL_ADDR_CONV_A)) begin
                    conv_a_reg <= wbyte;
                end
                if (is_addr(aw_addr_reg, `CCL_ADDR_CONV_CHAN)) begin
                    conv_chan_reg <= wbyte;
                end
                if (is_addr(aw_addr_reg, `CCL_ADDR_STATUS_WORD)) begin
                    status_word_reg <= wbyte;
                end
                if (is_addr(aw_addr_reg, `CCL_ADDR_DIDR)) begin
                    didr_reg <= merge_byte(didr_reg, wbyte, `CCL_DIDR_WMASK);
                end
                if (is_addr(aw_addr_reg, `CCL_ADDR_COMP_CS)) begin
                    comp_disable_reg <= wbyte[`CCL_CS_DISABLE];
                    bandgap_sel_reg  <= wbyte[`CCL_CS_BANDGAP];
                    irq_en_reg       <= wbyte[`CCL_CS_IRQEN];
                    event_mode_reg   <= wbyte[1:0];
                end
            end
        end
    end

    // Comparator control/status view, reserved bit 2 reads zero
    assign cs_view = {comp_disable_reg, bandgap_sel_reg, sync2_reg, event_flag_reg,
                      irq_en_reg, 1'b0, event_mode_reg};

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                if (is_addr(s_axi_araddr, `CCL_ADDR_CONV_B)) begin
                    s_axi_rdata <= {24'h000000, conv_b_reg};
                end else if (is_addr(s_axi_araddr, `CCL_ADDR_COMP_CS)) begin
                    s_axi_rdata <= {24'h000000, cs_view};
                end else if (is_addr(s_axi_araddr, `CCL_ADDR_DIDR)) begin
                    s_axi_rdata <= {24'h000000, didr_reg};
                end else if (is_addr(s_axi_araddr, `CCL_ADDR_CONV_A)) begin
                    s_axi_rdata <= {24'h000000, conv_a_reg};
                end else if (is_addr(s_axi_araddr, `CCL_ADDR_CONV_CHAN)) begin
                    s_axi_rdata <= {24'h000000, conv_chan_reg};
                end else if (is_addr(s_axi_araddr, `CCL_ADDR_STATUS_WORD)) begin
                    s_axi_rdata <= {24'h000000, status_word_reg};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            end
        end
    end

    // Pin-side outputs, all registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            comparator_power_off   <= 1'b0;
            positive_pin_input_off <= 1'b0;
            negative_pin_input_off <= 1'b0;
            positive_pin_status    <= 1'b0;
            negative_pin_status    <= 1'b0;
            comparator_irq         <= 1'b0;
        end else begin
            comparator_power_off   <= comp_disable_reg;
            positive_pin_input_off <= didr_reg[`CCL_DIDR_POS];
            negative_pin_input_off <= didr_reg[`CCL_DIDR_NEG];
            positive_pin_status    <= positive_pin_digital & ~didr_reg[`CCL_DIDR_POS];
            negative_pin_status    <= negative_pin_digital & ~didr_reg[`CCL_DIDR_NEG];
            comparator_irq         <= event_flag_next & irq_en_reg
                                      & status_word_reg[`CCL_SW_GLOBAL_IE];
        end
    end

endmodule
`default_nettype wire

// File: test/ccl_props.sv
// Concurrent checks on the comparator control ports
`timescale 1ns/1ps
`default_nettype none
module ccl_props #(
    parameter ADDR_W = 6
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              positive_pin_digital,
    input wire logic              negative_pin_digital,
    input wire logic              positive_pin_input_off,
    input wire logic              negative_pin_input_off,
    input wire logic              positive_pin_status,
    input wire logic              negative_pin_status,
    input wire logic              comparator_power_off
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write handshakes on both channels at once
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_power_mirror: assert property (s_wr and s_axi_awaddr == 6'h20 |-> ##2
        comparator_power_off == $past(s_axi_wdata[7], 2)) else $error("power off not following disable bit");
    a_input_off: assert property (s_wr and s_axi_awaddr == 6'h24 |-> ##2
        {negative_pin_input_off, positive_pin_input_off} == $past(s_axi_wdata[5:4], 2))
        else $error("input disable outputs wrong");
    a_pin_gate: assert property ($past(aresetn) && $past(aresetn, 2) |->
        positive_pin_status == ($past(positive_pin_digital) && !positive_pin_input_off) &&
        negative_pin_status == ($past(negative_pin_digital) && !negative_pin_input_off))
        else $error("pin status not gated");
    a_write_answer: assert property (s_wr |=> s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_rd |-> s_axi_rvalid) else $error("no read data");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    a_cs_reserved: assert property (s_rd and s_axi_araddr == 6'h20 |->
        !s_axi_rdata[2] && s_axi_rdata[31:8] == 24'h0) else $error("control reserved bit set");
    a_didr_reserved: assert property (s_rd and s_axi_araddr == 6'h24 |->
        s_axi_rdata[31:6] == 26'h0 && s_axi_rdata[3:0] == 4'h0) else $error("input disable reserved set");
    a_unmapped_err: assert property (s_rd and s_axi_araddr == 6'h3C |-> ##0
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind ccl_comparator_control ccl_props #(.ADDR_W(ADDR_W)) i_ccl_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .positive_pin_digital(positive_pin_digital),
    .negative_pin_digital(negative_pin_digital), .positive_pin_input_off(positive_pin_input_off),
    .negative_pin_input_off(negative_pin_input_off), .positive_pin_status(positive_pin_status),
    .negative_pin_status(negative_pin_status), .comparator_power_off(comparator_power_off)
);
`default_nettype wire

// File: test/ccl_analog_model.sv
// Behavioural analog front end driving the comparator inputs
`timescale 1ns/1ps
`default_nettype none
module ccl_analog_model (
    input  wire logic       aclk,
    input  wire logic [6:0] level_cmd,
    output var  logic       positive_input_pin,
    output var  logic       negative_input_pin,
    output var  logic [3:0] converter_pin,
    output var  logic       bandgap_level
);
    // Levels settle one cycle after a command, 1 meaning higher voltage
    always @(posedge aclk) begin
        {bandgap_level, positive_input_pin, negative_input_pin, converter_pin} <= level_cmd;
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Register-level bench for the comparator control logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vector_taken;
    logic        awready, wready, bvalid, arready, rvalid, pin_p, pin_n, bg, pwr, poff, noff, pst, nst, irq;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, rr, br;
    logic [6:0]  lvl;
    logic [3:0]  conv;
    int          errors, total_checks, cyc, m;
    ccl_comparator_control #(.ADDR_W(6)) i_ccl_comparator_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .positive_input_pin(pin_p), .negative_input_pin(pin_n),
        .converter_pin(conv), .bandgap_level(bg), .positive_pin_digital(pin_p), .negative_pin_digital(pin_n),
        .vector_taken(vector_taken), .comparator_power_off(pwr), .positive_pin_input_off(poff),
        .negative_pin_input_off(noff), .positive_pin_status(pst), .negative_pin_status(nst), .comparator_irq(irq));
    ccl_analog_model i_ccl_analog_model (.aclk(aclk), .level_cmd(lvl), .positive_input_pin(pin_p),
        .negative_input_pin(pin_n), .converter_pin(conv), .bandgap_level(bg));
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_of_test;
        end
    end
    task end_of_test;
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Write with address and data offered together
    task wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // Level bits: bandgap, positive, negative, converter pins
    task setl(input logic [6:0] v);
        lvl <= v;
        repeat (6) @(posedge aclk);
    endtask
    task cs_out(input logic e);
        rd(6'h20);
        chk(d[5], e);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, vector_taken} = 7'h00;
        {awaddr, araddr, wdata, lvl, errors, total_checks, cyc} = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(6'h0C); chk(d, 32'h0); chk(rr, 2'h0);
        rd(6'h20); chk(d, 32'h0);
        rd(6'h24); chk(d, 32'h0);
        wr(6'h0C, 8'hFF); chk(br, 2'h0); rd(6'h0C); chk(d, 32'h57);
        wr(6'h24, 8'hFF); rd(6'h24); chk(d, 32'h30);
        setl(7'h30); chk({noff, poff, nst, pst}, 4'hC);
        wr(6'h24, 8'h00); repeat (2) @(posedge aclk); chk({nst, pst}, 2'h3);
        rd(6'h3C); chk({rr, d[7:0]}, 10'h200);
        wr(6'h3C, 8'hFF); chk(br, 2'h2);
        // Mux on, converter off: codes 0-3 pick converter pins, 4 the dedicated pin
        for (m = 0; m < 5; m++) begin
            wr(6'h2C, m[7:0]);
            setl({3'h3, ~(4'h1 << m[1:0])});
            cs_out(m < 4);
        end
        wr(6'h2C, 8'h00); wr(6'h28, 8'h80); setl(7'h2F); cs_out(1'b1);
        wr(6'h28, 8'h00); wr(6'h0C, 8'h00); setl(7'h21); cs_out(1'b1);
        wr(6'h20, 8'h40); setl(7'h40); cs_out(1'b1); setl(7'h20); cs_out(1'b0);
        // Every mode code on a rising then a falling output, enable kept clear
        for (m = 0; m < 4; m++) begin
            setl(7'h00); wr(6'h20, 8'h10 | m[7:0]);
            setl(7'h20); rd(6'h20); chk(d[4], m == 0 || m == 3);
            wr(6'h20, 8'h10 | m[7:0]); setl(7'h00); rd(6'h20); chk(d[4], m == 0 || m == 2);
        end
        wr(6'h20, 8'h13); setl(7'h20); wr(6'h20, 8'h0B); rd(6'h20); chk(d[4], 1'b1);
        chk(irq, 1'b0);
        wr(6'h30, 8'h80); repeat (2) @(posedge aclk); chk(irq, 1'b1);
        vector_taken <= 1'b1;
        @(posedge aclk);
        vector_taken <= 1'b0;
        repeat (2) @(posedge aclk); chk(irq, 1'b0); rd(6'h20); chk(d[4], 1'b0);
        wr(6'h20, 8'h00); wr(6'h20, 8'h90); repeat (2) @(posedge aclk); chk(pwr, 1'b1);
        setl(7'h00); rd(6'h20); chk(d[5:4], 2'h2);
        // Mid-run reset brings registers and outputs back to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(pwr, 1'b0); rd(6'h20); chk(d, 32'h0); rd(6'h0C); chk(d, 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
